// ### src/drive_command_word_decoder.sv
/*
 * Decoder of the fieldbus command word under the converting profile. It
 * holds the accepted word and reference, runs the drive sequencing state
 * machine and drives the stop, ramp, jog, fault reset, location and
 * application outputs.
 * Assumes all inputs, the configuration selects included, come from logic
 * on ref_clk, and that the drive reports a stopped motor and active fault.
 */
`timescale 1ns/10ps
module drive_command_word_decoder (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic cmd_valid,
    input wire logic [drive_cmd_pkg::CMD_W-1:0] cmd_word,
    input wire logic [drive_cmd_pkg::REF_W-1:0] ref_word,
    input wire logic run_en_from_bus,
    input wire logic run_en_ext,
    input wire logic ramp_in_from_bus,
    input wire logic reset_from_bus,
    input wire logic jog_from_bus,
    input wire logic location_from_bus,
    input wire logic fault_active,
    input wire logic motor_stopped,
    output drive_cmd_pkg::seq_state_e seq_state,
    output drive_cmd_pkg::stop_mode_e stop_mode,
    output logic ramp_out_zero,
    output logic ramp_hold,
    output logic ramp_in_zero,
    output logic jog1_req,
    output logic jog2_req,
    output logic fault_reset,
    output logic location_b_sel,
    output logic [drive_cmd_pkg::APP_W-1:0] app_bits,
    output logic bus_ctl_en,
    output logic ref_ramp_lock,
    output logic [drive_cmd_pkg::CMD_W-1:0] drive_cmd,
    output logic [drive_cmd_pkg::REF_W-1:0] drive_ref
);
    import drive_cmd_pkg::*;

    logic all_zero;
    logic accept;
    logic [CMD_W-1:0] held_cmd;
    logic [REF_W-1:0] held_ref;
    logic ramp_stop_ctl;
    logic coast_stop_ctl;
    logic quick_stop_ctl;
    logic permit;
    logic run_en_eff;
    logic go_enable;
    logic reset_prev_r;
    logic reset_rise;
    seq_state_e state_r;
    seq_state_e state_nxt;
    stop_mode_e stop_mode_nxt;
    logic bus_ctl_en_r;
    logic ref_ramp_lock_r;

    // A word is taken when remote control is on, or when word and
    // reference are both zero; otherwise the previous pair stays in force.
    assign all_zero = (cmd_word == CMD_ZERO) && (ref_word == REF_ZERO);
    assign accept = cmd_valid && (cmd_word[BIT_REMOTE] || all_zero);

    // The accepted pair becomes the drive's own command representation.
    cmd_hold u_hold (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .wr_en(accept),
        .cmd_word(cmd_word),
        .ref_word(ref_word),
        .held_cmd(held_cmd),
        .held_ref(held_ref)
    );

    assign drive_cmd = held_cmd;
    assign drive_ref = held_ref;

    // Control gating follows each received word, accepted or not.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_ctl_en_r <= 1'b0;
            ref_ramp_lock_r <= 1'b0;
        end else if (cmd_valid) begin
            bus_ctl_en_r <= accept;
            ref_ramp_lock_r <= !cmd_word[BIT_REMOTE] && all_zero;
        end
    end

    assign bus_ctl_en = bus_ctl_en_r;
    assign ref_ramp_lock = ref_ramp_lock_r;

    // Individual controls taken from the held word.
    assign ramp_stop_ctl = held_cmd[BIT_RAMP_STOP];
    assign coast_stop_ctl = held_cmd[BIT_COAST_STOP];
    assign quick_stop_ctl = held_cmd[BIT_QUICK_STOP];
    assign permit = held_cmd[BIT_PERMIT];

    // With a bus run enable the permit bit is the run enable itself.
    assign run_en_eff = run_en_from_bus ? permit : run_en_ext;
    assign go_enable = permit && run_en_eff;

    // Rising edge of the reset bit; only accepted words change held_cmd.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reset_prev_r <= 1'b0;
        end else begin
            reset_prev_r <= held_cmd[BIT_RESET];
        end
    end

    assign reset_rise = held_cmd[BIT_RESET] && !reset_prev_r;

    // Fault reset is a one-cycle pulse, and a steady level does nothing.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_reset <= 1'b0;
        end else begin
            fault_reset <= reset_rise && fault_active && reset_from_bus;
        end
    end

    // Strongest stop request wins when several are asked together.
    always_comb begin
        if (!coast_stop_ctl) begin
            stop_mode_nxt = stop_coast;
        end else if (!quick_stop_ctl) begin
            stop_mode_nxt = stop_quick;
        end else if (!ramp_stop_ctl) begin
            stop_mode_nxt = stop_ramp;
        end else begin
            stop_mode_nxt = stop_none;
        end
    end

    // Decoded ramp, jog, location and application outputs, one flop each.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            stop_mode <= stop_none;
            ramp_out_zero <= 1'b1;
            ramp_hold <= 1'b1;
            ramp_in_zero <= 1'b0;
            jog1_req <= 1'b0;
            jog2_req <= 1'b0;
            location_b_sel <= 1'b0;
            app_bits <= APP_RESET;
        end else begin
            stop_mode <= stop_mode_nxt;
            ramp_out_zero <= !held_cmd[BIT_RAMP_OUT];
            ramp_hold <= !held_cmd[BIT_RAMP_HOLD];
            ramp_in_zero <= ramp_in_from_bus && !held_cmd[BIT_RAMP_IN];
            jog1_req <= jog_from_bus && held_cmd[BIT_JOG1];
            jog2_req <= jog_from_bus && held_cmd[BIT_JOG2];
            location_b_sel <= location_from_bus && held_cmd[BIT_LOCATION];
            app_bits <= held_cmd[BIT_APP_HI:BIT_APP_LO];
        end
    end

    // Sequencing. A fault overrides everything, then coast, then quick
    // stop; a fresh start out of inhibit needs the ramp-stop bit at 0 first
    // so that a tripped drive cannot restart on a standing run word.
    always_comb begin
        state_nxt = state_r;
        if (fault_active && state_r != st_fault) begin
            state_nxt = st_fault;
        end else if (state_r == st_fault) begin
            if (fault_reset) begin
                state_nxt = st_sw_on_inhibited;
            end
        end else if (!coast_stop_ctl && state_r != st_off2_active
                     && state_r != st_sw_on_inhibited) begin
            state_nxt = st_off2_active;
        end else if (!quick_stop_ctl && state_r != st_off2_active
                     && state_r != st_off3_active
                     && state_r != st_sw_on_inhibited) begin
            state_nxt = st_off3_active;
        end else begin
            case (state_r)
                st_sw_on_inhibited: begin
                    if (coast_stop_ctl && quick_stop_ctl && !ramp_stop_ctl) begin
                        state_nxt = st_ready_sw_on;
                    end
                end
                st_ready_sw_on: begin
                    if (ramp_stop_ctl) begin
                        state_nxt = st_ready_operate;
                    end
                end
                st_ready_operate: begin
                    if (!ramp_stop_ctl) begin
                        state_nxt = st_ready_sw_on;
                    end else if (go_enable) begin
                        state_nxt = st_op_enabled;
                    end
                end
                st_op_enabled: begin
                    if (!ramp_stop_ctl) begin
                        state_nxt = st_off1_active;
                    end else if (!go_enable) begin
                        state_nxt = st_op_inhibited;
                    end
                end
                st_op_inhibited: begin
                    if (!ramp_stop_ctl) begin
                        state_nxt = st_off1_active;
                    end else if (go_enable) begin
                        state_nxt = st_op_enabled;
                    end
                end
                st_off1_active: begin
                    if (motor_stopped) begin
                        state_nxt = st_ready_sw_on;
                    end
                end
                st_off2_active: begin
                    if (motor_stopped) begin
                        state_nxt = st_sw_on_inhibited;
                    end
                end
                st_off3_active: begin
                    if (motor_stopped) begin
                        state_nxt = st_sw_on_inhibited;
                    end
                end
                default: begin
                    state_nxt = st_sw_on_inhibited;
                end
            endcase
        end
    end

    // State register.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= st_sw_on_inhibited;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign seq_state = state_r;

    // Checks on the decoder, all on ref_clk and idle during reset.
    default clocking dflt_cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    sequence rejected_word_s;
        cmd_valid && !cmd_word[BIT_REMOTE] && !all_zero;
    endsequence

    sequence zero_word_s;
        cmd_valid && !cmd_word[BIT_REMOTE] && all_zero;
    endsequence

    sequence reset_edge_s;
        !held_cmd[BIT_RESET] ##1 held_cmd[BIT_RESET] && fault_active && reset_from_bus;
    endsequence

    hold_keep_a: assert property (
        rejected_word_s |=> $stable(held_cmd) && $stable(held_ref) && !bus_ctl_en)
        else $error("rejected word changed the held command");

    hold_take_a: assert property (
        cmd_valid && cmd_word[BIT_REMOTE]
        |=> held_cmd == $past(cmd_word) && held_ref == $past(ref_word) && bus_ctl_en)
        else $error("remote word was not taken");

    zero_lock_a: assert property (
        zero_word_s |=> ref_ramp_lock && bus_ctl_en && held_cmd == CMD_ZERO)
        else $error("all zero word did not lock reference and ramp");

    stop_priority_a: assert property (
        !coast_stop_ctl && !quick_stop_ctl |=> stop_mode == stop_coast)
        else $error("coast stop lost priority");

    coast_entry_a: assert property (
        !fault_active && !coast_stop_ctl && state_r inside {st_op_enabled,
        st_off1_active, st_off3_active, st_ready_operate}
        |=> state_r == st_off2_active)
        else $error("coast stop did not enter its stop state");

    quick_exit_a: assert property (
        !fault_active && state_r == st_off3_active && motor_stopped && coast_stop_ctl
        |=> state_r == st_sw_on_inhibited)
        else $error("quick stop did not end in switch-on inhibited");

    ramp_exit_a: assert property (
        !fault_active && state_r == st_off1_active && motor_stopped
        && coast_stop_ctl && quick_stop_ctl |=> state_r == st_ready_sw_on)
        else $error("ramp stop did not end in ready to switch on");

    enable_run_a: assert property (
        !fault_active && state_r == st_ready_operate && held_cmd[2:0] == 3'h7
        && permit && run_en_eff |=> state_r == st_op_enabled)
        else $error("permit with run enable did not enable operation");

    bus_run_a: assert property (
        !fault_active && run_en_from_bus && !permit && state_r == st_op_enabled
        && held_cmd[2:0] == 3'h7 |=> state_r == st_op_inhibited)
        else $error("bus run enable did not follow permit bit");

    ready_step_a: assert property (
        !fault_active && state_r == st_ready_sw_on && held_cmd[2:0] == 3'h7
        |=> state_r == st_ready_operate)
        else $error("ramp stop bit did not advance the state");

    reset_pulse_a: assert property (
        reset_edge_s |=> fault_reset ##1 !fault_reset)
        else $error("reset edge gave no single fault reset pulse");

    reset_level_a: assert property (
        held_cmd[BIT_RESET] && $stable(held_cmd[BIT_RESET]) |=> !fault_reset)
        else $error("steady reset bit caused a fault reset");

    jog_gate_a: assert property (
        !jog_from_bus && !ramp_in_from_bus |=> !jog1_req && !jog2_req && !ramp_in_zero)
        else $error("bus bit acted without bus source");

    ramp_bits_a: assert property (
        1'b1 |=> ramp_out_zero == !$past(held_cmd[BIT_RAMP_OUT])
        && ramp_hold == !$past(held_cmd[BIT_RAMP_HOLD]))
        else $error("ramp clamp or freeze out of step with word");

    app_pass_a: assert property (
        accept |=> ##1 app_bits == $past(cmd_word[BIT_APP_HI:BIT_APP_LO], 2))
        else $error("application bits not passed through");

    location_a: assert property (
        accept && location_from_bus ##1 location_from_bus
        |=> location_b_sel == $past(cmd_word[BIT_LOCATION], 2))
        else $error("location select does not follow word");

endmodule : drive_command_word_decoder

// ### src/drive_cmd_pkg.sv
/*
 * Constants and types shared by the drive command word decoder and its
 * command holding store: word widths, bit positions, reset values and the
 * enumerations of sequencing states and stop modes.
 * Assumes a single system clock domain for every user of these names.
 */
package drive_cmd_pkg;

    // Widths of the command word and of the reference word.
    localparam int CMD_W = 16;
    localparam int REF_W = 16;
    localparam int APP_W = 4;

    // Bit positions inside the command word.
    localparam int BIT_RAMP_STOP = 0;
    localparam int BIT_COAST_STOP = 1;
    localparam int BIT_QUICK_STOP = 2;
    localparam int BIT_PERMIT = 3;
    localparam int BIT_RAMP_OUT = 4;
    localparam int BIT_RAMP_HOLD = 5;
    localparam int BIT_RAMP_IN = 6;
    localparam int BIT_RESET = 7;
    localparam int BIT_JOG1 = 8;
    localparam int BIT_JOG2 = 9;
    localparam int BIT_REMOTE = 10;
    localparam int BIT_LOCATION = 11;
    localparam int BIT_APP_LO = 12;
    localparam int BIT_APP_HI = 15;

    // Reset and comparison values of the held words.
    localparam logic [CMD_W-1:0] CMD_RESET = 16'h0000;
    localparam logic [REF_W-1:0] REF_RESET = 16'h0000;
    localparam logic [CMD_W-1:0] CMD_ZERO = 16'h0000;
    localparam logic [REF_W-1:0] REF_ZERO = 16'h0000;
    localparam logic [APP_W-1:0] APP_RESET = 4'h0;

    // Sequencing states of the drive.
    typedef enum logic [3:0] {
        st_sw_on_inhibited,
        st_ready_sw_on,
        st_ready_operate,
        st_op_enabled,
        st_op_inhibited,
        st_off1_active,
        st_off2_active,
        st_off3_active,
        st_fault
    } seq_state_e;

    // Stop request handed to the ramp logic, strongest last.
    typedef enum logic [1:0] {
        stop_none,
        stop_ramp,
        stop_quick,
        stop_coast
    } stop_mode_e;

endpackage : drive_cmd_pkg

// ### src/cmd_hold.sv
/*
 * Holding store for the last accepted command word and reference.
 * Assumes the write enable and data come from logic on the same clock.
 */
`timescale 1ns/10ps
module cmd_hold (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic wr_en,
    input wire logic [drive_cmd_pkg::CMD_W-1:0] cmd_word,
    input wire logic [drive_cmd_pkg::REF_W-1:0] ref_word,
    output logic [drive_cmd_pkg::CMD_W-1:0] held_cmd,
    output logic [drive_cmd_pkg::REF_W-1:0] held_ref
);
    import drive_cmd_pkg::*;

    // Both words load together so the pair never splits.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            held_cmd <= CMD_RESET;
            held_ref <= REF_RESET;
        end else if (wr_en) begin
            held_cmd <= cmd_word;
            held_ref <= ref_word;
        end
    end

endmodule : cmd_hold

// ### tb/fb_master_model.sv
/*
 * Behavioural model of the fieldbus master that hands command words and
 * references to the decoder, promptly or after idle cycles.
 * Assumes callers enter send shortly after a rising edge of ref_clk.
 */
`timescale 1ns/10ps
module fb_master_model (
    input wire logic ref_clk,
    output logic cmd_valid,
    output logic [drive_cmd_pkg::CMD_W-1:0] cmd_word,
    output logic [drive_cmd_pkg::REF_W-1:0] ref_word
);
    import drive_cmd_pkg::*;

    // Idle lines carry no stale value, so the decoder cannot profit from one.
    initial begin
        cmd_valid = 1'b0;
        cmd_word = 16'hffff;
        ref_word = 16'hffff;
    end

    // Sends one word and reference as a pair; hold keeps valid up for a
    // back-to-back word, otherwise the lines show the inverse afterwards.
    task automatic send(input logic [CMD_W-1:0] w, input logic [REF_W-1:0] r,
                        input int gap, input bit hold);
        repeat (gap) begin
            @(posedge ref_clk);
            #1;
        end
        cmd_valid = 1'b1;
        cmd_word = w;
        ref_word = r;
        @(posedge ref_clk);
        #1;
        if (!hold) begin
            cmd_valid = 1'b0;
            cmd_word = ~w;
            ref_word = ~r;
        end
    endtask : send
endmodule : fb_master_model

// ### tb/testbench.sv
/*
 * Self-checking bench of the command word decoder: words are sent through
 * the master model and the decoded outputs compared with the expected ones.
 * Assumes the design files and fb_master_model are compiled before it.
 */
`timescale 1ns/10ps
module testbench;
    import drive_cmd_pkg::*;

    logic ref_clk, arst_n, run_en_from_bus, run_en_ext, ramp_in_from_bus;
    logic reset_from_bus, jog_from_bus, location_from_bus, fault_active;
    logic motor_stopped, ramp_out_zero, ramp_hold, ramp_in_zero, jog1_req;
    logic jog2_req, fault_reset, location_b_sel, bus_ctl_en, ref_ramp_lock;
    wire logic cmd_valid;
    wire logic [CMD_W-1:0] cmd_word;
    wire logic [REF_W-1:0] ref_word;
    logic [APP_W-1:0] app_bits;
    logic [CMD_W-1:0] drive_cmd;
    logic [REF_W-1:0] drive_ref;
    seq_state_e seq_state;
    stop_mode_e stop_mode;
    int n_fail = 0;
    int cmp_count = 0;
    int pulses;

    fb_master_model u_fb_master_model (.ref_clk(ref_clk), .cmd_valid(cmd_valid),
        .cmd_word(cmd_word), .ref_word(ref_word));

    drive_command_word_decoder u_drive_command_word_decoder (.ref_clk(ref_clk),
        .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
        .ref_word(ref_word), .run_en_from_bus(run_en_from_bus), .run_en_ext(run_en_ext),
        .ramp_in_from_bus(ramp_in_from_bus), .reset_from_bus(reset_from_bus),
        .jog_from_bus(jog_from_bus), .location_from_bus(location_from_bus),
        .fault_active(fault_active), .motor_stopped(motor_stopped),
        .seq_state(seq_state), .stop_mode(stop_mode), .ramp_out_zero(ramp_out_zero),
        .ramp_hold(ramp_hold), .ramp_in_zero(ramp_in_zero), .jog1_req(jog1_req),
        .jog2_req(jog2_req), .fault_reset(fault_reset), .location_b_sel(location_b_sel),
        .app_bits(app_bits), .bus_ctl_en(bus_ctl_en), .ref_ramp_lock(ref_ramp_lock),
        .drive_cmd(drive_cmd), .drive_ref(drive_ref));

    // Clock of 5 ns period.
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Prints the verdict and ends the run.
    task automatic conclude();
        if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude

    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [15:0] act, input logic [15:0] exp);
        cmp_count++;
        if (act !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, act, exp);
        end
    endtask : chk

    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : wait_n

    // Sends a word with reference and lets the sequencer settle.
    task automatic put(input logic [15:0] w, input logic [15:0] r);
        u_fb_master_model.send(w, r, 0, 1'b0);
        wait_n(6);
    endtask : put

    task automatic chk_st(input seq_state_e e);
        chk({12'h000, seq_state}, {12'h000, e});
    endtask : chk_st

    task automatic chk_stop(input stop_mode_e e);
        chk({14'h0000, stop_mode}, {14'h0000, e});
    endtask : chk_stop

    // Bounds the run if the design hangs.
    initial begin
        #50000;
        n_fail++;
        conclude();
    end

    // Main sequence of scenarios.
    initial begin
        arst_n = 1'b0;
        {run_en_from_bus, ramp_in_from_bus, jog_from_bus, location_from_bus} = 4'hf;
        {run_en_ext, reset_from_bus, fault_active, motor_stopped} = 4'h0;
        repeat (20) @(posedge ref_clk);
        #1;
        arst_n = 1'b1;
        wait_n(3);
        chk_st(st_sw_on_inhibited);
        chk_stop(stop_coast);
        chk(drive_cmd, 16'h0000);
        chk({15'h0000, ramp_out_zero}, 16'h0001);
        // Start-up out of switch-on-inhibited into operation.
        put(16'h0406, 16'h0000);
        chk_st(st_ready_sw_on);
        chk_stop(stop_ramp);
        chk(drive_cmd, 16'h0406);
        put(16'h047f, 16'h0000);
        chk_st(st_op_enabled);
        chk_stop(stop_none);
        chk({13'h0000, ramp_out_zero, ramp_hold, ramp_in_zero}, 16'h0000);
        // Permit bit and the source of run enable.
        put(16'h0477, 16'h0000);
        chk_st(st_op_inhibited);
        run_en_from_bus = 1'b0;
        put(16'h047f, 16'h0000);
        chk_st(st_op_inhibited);
        run_en_ext = 1'b1;
        wait_n(6);
        chk_st(st_op_enabled);
        // Ramp stop waits for standstill before ready-to-switch-on.
        put(16'h047e, 16'h0000);
        chk_st(st_off1_active);
        motor_stopped = 1'b1;
        wait_n(4);
        chk_st(st_ready_sw_on);
        motor_stopped = 1'b0;
        // Coast stop wins over the other stops.
        put(16'h0400, 16'h0000);
        chk_st(st_off2_active);
        chk_stop(stop_coast);
        motor_stopped = 1'b1;
        wait_n(4);
        chk_st(st_sw_on_inhibited);
        motor_stopped = 1'b0;
        // Quick stop from operation, with ramp stop requested too.
        put(16'h0406, 16'h0000);
        put(16'h047f, 16'h0000);
        put(16'h047a, 16'h0000);
        chk_st(st_off3_active);
        chk_stop(stop_quick);
        motor_stopped = 1'b1;
        wait_n(4);
        chk_st(st_sw_on_inhibited);
        motor_stopped = 1'b0;
        // Jog, location, application and ramp clamp bits.
        put(16'h5f06, 16'h0000);
        chk({12'h000, jog1_req, jog2_req, location_b_sel, ramp_in_zero}, 16'h000f);
        chk({12'h000, app_bits}, 16'h0005);
        chk({14'h0000, ramp_out_zero, ramp_hold}, 16'h0003);
        {ramp_in_from_bus, jog_from_bus, location_from_bus} = 3'h0;
        wait_n(3);
        chk({12'h000, jog1_req, jog2_req, location_b_sel, ramp_in_zero}, 16'h0000);
        {ramp_in_from_bus, jog_from_bus, location_from_bus} = 3'h7;
        put(16'ha506, 16'h0000);
        chk({12'h000, jog1_req, jog2_req, location_b_sel, app_bits[3]}, 16'h0009);
        chk({12'h000, app_bits}, 16'h000a);
        // Back-to-back words: the second lacks remote control and is refused.
        u_fb_master_model.send(16'h0406, 16'h0100, 0, 1'b1);
        u_fb_master_model.send(16'h0003, 16'h1234, 0, 1'b0);
        wait_n(2);
        chk(drive_cmd, 16'h0406);
        chk(drive_ref, 16'h0100);
        chk({14'h0000, bus_ctl_en, ref_ramp_lock}, 16'h0000);
        put(16'h0000, 16'h0000);
        chk(drive_ref, 16'h0000);
        chk({14'h0000, bus_ctl_en, ref_ramp_lock}, 16'h0003);
        // Fault reset needs a rising reset bit and the bus as its source.
        fault_active = 1'b1;
        wait_n(3);
        chk_st(st_fault);
        put(16'h0400, 16'h0000);
        for (int pass = 0; pass < 2; pass++) begin
            reset_from_bus = pass[0];
            if (pass == 1) put(16'h0400, 16'h0000);
            u_fb_master_model.send(16'h0480, 16'h0000, 0, 1'b0);
            pulses = 0;
            for (int i = 0; i < 6; i++) begin
                wait_n(1);
                if (fault_reset === 1'b1) begin
                    pulses++;
                    fault_active = 1'b0;
                end
            end
            chk(16'(pulses), 16'(pass));
        end
        chk_st(st_sw_on_inhibited);
        conclude();
    end
endmodule : testbench
